// ### include/ufpc_pkg.sv
// constants shared by both ends of the transceiver control block
// assumes byte wide special function register access on one clock
package ufpc_pkg;
  // direct register byte addresses
  localparam logic [7:0] ADR_OFS = 8'h96; // indirect_address_reg
  localparam logic [7:0] DAT_OFS = 8'h97; // indirect_data_reg
  localparam logic [7:0] XCN_OFS = 8'hd7; // transceiver_control
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // transceiver_control field positions
  localparam int XCN_PULLUP_ENABLE  = 7;
  localparam int XCN_PHY_ENABLE = 6;
  localparam int XCN_SPEED = 5;
  localparam int XCN_TSTHI = 4;
  localparam int XCN_TSTLO = 3;
  localparam int XCN_DIFF_RECEIVE_STATE = 2;
  localparam int XCN_DP    = 1;
  localparam int XCN_DM    = 0;
  // indirect_address_reg field positions
  localparam int ADR_BUSY  = 7;
  localparam int ADR_AUTO  = 6;
  localparam int ADR_W     = 6;
  // phy_test_select codes
  localparam logic [1:0] TST_NORMAL = 2'h0;
  localparam logic [1:0] TST_DIFF1  = 2'h1;
  localparam logic [1:0] TST_DIFF0  = 2'h2;
  localparam logic [1:0] TST_SE0    = 2'h3;
  // endpoint protocol addresses
  localparam logic [7:0] EP0_ADDR     = 8'h00;
  localparam logic [7:0] EP_OUT_FIRST = 8'h01;
  localparam logic [7:0] EP_OUT_LAST  = 8'h03;
  localparam logic [7:0] EP_IN_FIRST  = 8'h81;
  localparam logic [7:0] EP_IN_LAST   = 8'h83;
  // core register layout
  localparam logic [5:0] INDEX_ADDR = 6'h0e; // endpoint index selector
  localparam logic [5:0] IDX_BASE   = 6'h10; // first indexed register
  localparam logic [5:0] IDX_END    = 6'h20; // past last indexed register
  localparam int NUM_EP   = 4;
  localparam int NUM_REGS = 16;
  // cycles from fetch launch to bank read request
  localparam int FETCH_CYCLES = 2;
  // firmware side command kinds
  typedef enum logic [1:0] {
    CMD_IND_READ  = 2'h0,
    CMD_IND_WRITE = 2'h1,
    CMD_XCN_WRITE = 2'h2,
    CMD_XCN_READ  = 2'h3
  } ufpc_cmd_t;
endpackage : ufpc_pkg

// ### include/ufpc_sfr_if.sv
// register access path between firmware engine and device end
// assumes both ends share one clock; no clocking block
`timescale 1ns/1ps
interface ufpc_sfr_if;
  logic [7:0] sfr_addr;       // direct register address
  logic       sfr_wr;         // write strobe
  logic       sfr_rd;         // read strobe
  logic [7:0] sfr_wdata;      // write data
  logic [7:0] sfr_rdata;      // read data, one cycle after sfr_rd
  logic       usb_clk_active; // usb clock running
  modport dev (
    input  sfr_addr,
    input  sfr_wr,
    input  sfr_rd,
    input  sfr_wdata,
    output sfr_rdata,
    output usb_clk_active
  );
  modport host (
    output sfr_addr,
    output sfr_wr,
    output sfr_rd,
    output sfr_wdata,
    input  sfr_rdata,
    input  usb_clk_active
  );
endinterface : ufpc_sfr_if

// ### verilog/ufpc_core_regs.sv
// indirect core register bank with endpoint indexed window
// assumes requests come from the device end on the same clock
`timescale 1ns/1ps
module ufpc_core_regs (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       req,
  input  wire logic       we,
  input  wire logic [5:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);
  typedef struct packed {
    logic [7:0] rdata; // registered read data
  } ufpc_bank_state_t;

  ufpc_bank_state_t s;       // current state
  ufpc_bank_state_t next_s;  // next state
  logic [7:0] common [ufpc_pkg::NUM_REGS];                    // common regs
  logic [7:0] indexed [ufpc_pkg::NUM_EP][ufpc_pkg::NUM_REGS]; // per pipe
  logic [1:0] ep_sel;        // endpoint from index selector

  // low bits of the index selector pick the endpoint
  assign ep_sel = common[ufpc_pkg::INDEX_ADDR[3:0]][1:0];
  assign rdata  = s.rdata;

  // true when the address falls in the indexed window
  function automatic logic is_indexed(input logic [5:0] a);
    is_indexed = (a >= ufpc_pkg::IDX_BASE) && (a < ufpc_pkg::IDX_END);
  endfunction : is_indexed

  // read decode: indexed window follows the selected endpoint
  always_comb
  begin
    next_s = s;
    if (req && !we)
    begin
      if (is_indexed(addr))
        next_s.rdata = indexed[ep_sel][addr[3:0]]; // [RULE12]
      else if (addr < ufpc_pkg::IDX_BASE)
        next_s.rdata = common[addr[3:0]];
      else
        next_s.rdata = ufpc_pkg::RESET_BYTE;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  // bank storage; writes above the indexed window are dropped
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < ufpc_pkg::NUM_REGS; i++)
      begin
        common[i] <= ufpc_pkg::RESET_BYTE;
        for (int e = 0; e < ufpc_pkg::NUM_EP; e++)
          indexed[e][i] <= ufpc_pkg::RESET_BYTE;
      end
    end
    else if (req && we)
    begin
      if (is_indexed(addr))
        indexed[ep_sel][addr[3:0]] <= wdata; // [RULE12]
      else if (addr < ufpc_pkg::IDX_BASE)
        common[addr[3:0]] <= wdata;
    end
  end
endmodule : ufpc_core_regs

// ### verilog/ufpc_device.sv
// device end: transceiver control, line status, endpoint map and
// indirect access to the core register bank
// assumes firmware strobes on clk; line pins and vbus are asynchronous
`timescale 1ns/1ps
// Overview of operation
// [RULE1] endpoint zero answers at address 0x00 both ways
// [RULE2] pairs one to three: IN 0x81-83, OUT 0x01-03
// [RULE3] function only, never acts as host
// [RULE4] speed bit picks full/D+ or low/D- pull-up
// [RULE5] pull-up only with enable bit and vbus
// [RULE6] phy enable clear means suspend, set means normal
// [RULE7] test field forces line states per code
// [RULE8] enabled receiver bit shows differential bus state
// [RULE9] bits one and zero show live D+/D-
// [RULE10] firmware starts usb clock before phy enable
// [RULE11] core registers reached via address/data pair only
// [RULE12] indexed registers follow last written endpoint index
// [RULE13] usb clock must run during indirect access
// [RULE14] busy high while fetch runs, cleared when valid
// [RULE15] read: poll, load address, set busy, poll, read
// [RULE16] auto-read relaunches fetch on data register read
// [RULE17] write: poll, load address, write data register
// [RULE18] status bit writes ignored, always live
module ufpc_device #(
  parameter int FETCH_CYCLES = ufpc_pkg::FETCH_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  ufpc_sfr_if.dev         ifc,
  input  wire logic       usb_clk_on,
  input  wire logic       vbus_in,
  input  wire logic       dp_in,
  output logic            dp_out,
  output logic            dp_oe_n,
  input  wire logic       dm_in,
  output logic            dm_out,
  output logic            dm_oe_n,
  output logic            pullup_dp,
  output logic            pullup_dm,
  output logic            phy_suspend,
  output logic            full_speed,
  input  wire logic       tok_valid,
  input  wire logic [7:0] tok_addr,
  input  wire logic       tok_is_in,
  output logic            pipe_hit,
  output logic            pipe_in,
  output logic      [1:0] pipe_ep
);
  localparam logic [3:0] FETCH_CNT = 4'(FETCH_CYCLES); // launch delay
  localparam logic [3:0] CNT_ONE   = 4'h1;

  typedef struct packed {
    logic       pullup_enable;   // pull-up enable
    logic       phy_enable;      // transceiver enable
    logic       speed;           // 1 full, 0 low
    logic [1:0] phy_test_select; // line test code
    logic       busy;            // indirect fetch running
    logic       auto_read_next;  // relaunch on data read
    logic [5:0] indirect_target_address;
    logic [7:0] dat;             // indirect data register
    logic [3:0] cnt;             // fetch delay counter
    logic       cap;             // bank data due this cycle
    logic       bank_req;        // bank access strobe
    logic       bank_we;         // bank write select
    logic [7:0] bank_wdata;      // bank write data
    logic [1:0] dp_s;            // D+ synchroniser
    logic [1:0] dm_s;            // D- synchroniser
    logic [1:0] vb_s;            // vbus synchroniser
    logic [7:0] rdata;           // register read answer
    logic       clk_act;         // usb clock running
    logic       dp_out;
    logic       dp_oe_n;
    logic       dm_out;
    logic       dm_oe_n;
    logic       pullup_dp;
    logic       pullup_dm;
    logic       phy_suspend;
    logic       full_speed;
    logic       pipe_hit;
    logic       pipe_in;
    logic [1:0] pipe_ep;
  } ufpc_dev_state_t;

  ufpc_dev_state_t s;      // current state
  ufpc_dev_state_t next_s; // next state
  logic [7:0]      bank_rdata; // core bank read data
  logic            dplus_level;
  logic            dminus_level;
  logic            diff_receive_state;

  // synchronised line levels, second stage only
  assign dplus_level        = s.dp_s[1]; // [RULE9]
  assign dminus_level       = s.dm_s[1]; // [RULE9]
  assign diff_receive_state = s.phy_enable & dplus_level & ~dminus_level;

  // endpoint map: zero both ways, one to three as IN/OUT pairs
  function automatic logic ep_valid(input logic [7:0] a);
    ep_valid = (a == ufpc_pkg::EP0_ADDR) ||                  // [RULE1]
               (a >= ufpc_pkg::EP_OUT_FIRST &&
                a <= ufpc_pkg::EP_OUT_LAST) ||               // [RULE2]
               (a >= ufpc_pkg::EP_IN_FIRST &&
                a <= ufpc_pkg::EP_IN_LAST);                  // [RULE2]
  endfunction : ep_valid

  // live view of the transceiver control register
  function automatic logic [7:0] xcn_view(input ufpc_dev_state_t v,
                                          input logic df,
                                          input logic dp,
                                          input logic dm);
    xcn_view = {v.pullup_enable, v.phy_enable, v.speed,
                v.phy_test_select, df, dp, dm};
  endfunction : xcn_view

  ufpc_core_regs u_core (
    .clk   (clk),
    .rst_n (rst_n),
    .req   (s.bank_req),
    .we    (s.bank_we),
    .addr  (s.indirect_target_address),
    .wdata (s.bank_wdata),
    .rdata (bank_rdata)
  );

  // all next state: bus decode, fetch engine, pins, endpoint map
  always_comb
  begin
    next_s          = s;
    // two stage synchronisers
    next_s.dp_s     = {s.dp_s[0], dp_in};
    next_s.dm_s     = {s.dm_s[0], dm_in};
    next_s.vb_s     = {s.vb_s[0], vbus_in};
    next_s.clk_act  = usb_clk_on;
    next_s.bank_req = 1'b0;
    next_s.bank_we  = 1'b0;
    next_s.cap      = s.bank_req & ~s.bank_we;
    // fetched data lands, data now valid
    if (s.cap)
    begin
      next_s.dat  = bank_rdata;
      next_s.busy = 1'b0;                                 // [RULE14]
    end
    // fetch delay, bank read issued on last count
    if (s.cnt != 4'h0)
    begin
      next_s.cnt = s.cnt - CNT_ONE;
      if (s.cnt == CNT_ONE)
        next_s.bank_req = 1'b1;                           // [RULE11]
    end
    // register reads, answered next cycle
    if (ifc.sfr_rd)
    begin
      if (ifc.sfr_addr == ufpc_pkg::XCN_OFS)
        next_s.rdata = xcn_view(s, diff_receive_state,
                                dplus_level, dminus_level); // [RULE8]
      else if (ifc.sfr_addr == ufpc_pkg::ADR_OFS)
        next_s.rdata = {s.busy, s.auto_read_next,
                        s.indirect_target_address};       // [RULE14]
      else if (ifc.sfr_addr == ufpc_pkg::DAT_OFS)
      begin
        next_s.rdata = s.dat;                             // [RULE11]
        // auto-read: same address, new fetch
        if (s.auto_read_next && !s.busy)
        begin
          next_s.busy = 1'b1;                             // [RULE16]
          next_s.cnt  = FETCH_CNT;                        // [RULE16]
        end
      end
      else
        next_s.rdata = ufpc_pkg::RESET_BYTE;
    end
    // register writes
    if (ifc.sfr_wr)
    begin
      if (ifc.sfr_addr == ufpc_pkg::XCN_OFS)
      begin
        // status bits are not stored
        next_s.pullup_enable   = ifc.sfr_wdata[ufpc_pkg::XCN_PULLUP_ENABLE];
        next_s.phy_enable      = ifc.sfr_wdata[ufpc_pkg::XCN_PHY_ENABLE];
        next_s.speed           = ifc.sfr_wdata[ufpc_pkg::XCN_SPEED];
        next_s.phy_test_select =
          ifc.sfr_wdata[ufpc_pkg::XCN_TSTHI:ufpc_pkg::XCN_TSTLO]; // [RULE18]
      end
      else if (ifc.sfr_addr == ufpc_pkg::ADR_OFS && !s.busy)
      begin
        next_s.auto_read_next          = ifc.sfr_wdata[ufpc_pkg::ADR_AUTO];
        next_s.indirect_target_address =
          ifc.sfr_wdata[ufpc_pkg::ADR_W-1:0];             // [RULE15]
        // writing busy high launches a fetch
        if (ifc.sfr_wdata[ufpc_pkg::ADR_BUSY])
        begin
          next_s.busy = 1'b1;                             // [RULE15]
          next_s.cnt  = FETCH_CNT;                        // [RULE14]
        end
      end
      else if (ifc.sfr_addr == ufpc_pkg::DAT_OFS && !s.busy)
      begin
        // write straight through to the selected target
        next_s.bank_req   = 1'b1;                         // [RULE17]
        next_s.bank_we    = 1'b1;                         // [RULE17]
        next_s.bank_wdata = ifc.sfr_wdata;
        next_s.dat        = ifc.sfr_wdata;
      end
    end
    // pull-up placement; device only ever attaches, never hosts
    next_s.pullup_dp   = s.pullup_enable & s.vb_s[1] & s.speed;  // [RULE5]
    next_s.pullup_dm   = s.pullup_enable & s.vb_s[1] & ~s.speed; // [RULE4]
    next_s.full_speed  = s.speed;                                // [RULE4]
    next_s.phy_suspend = ~s.phy_enable;                          // [RULE6]
    // forced line states, released in normal mode; single ended zero
    // drives both lines low
    next_s.dp_oe_n = (s.phy_test_select == ufpc_pkg::TST_NORMAL); // [RULE7]
    next_s.dm_oe_n = (s.phy_test_select == ufpc_pkg::TST_NORMAL); // [RULE7]
    next_s.dp_out  = (s.phy_test_select == ufpc_pkg::TST_DIFF1);  // [RULE7]
    next_s.dm_out  = (s.phy_test_select == ufpc_pkg::TST_DIFF0);  // [RULE7]
    // token address to pipe lookup; never issues tokens itself
    next_s.pipe_hit = tok_valid & ep_valid(tok_addr);     // [RULE3]
    next_s.pipe_ep  = tok_addr[1:0];                      // [RULE2]
    next_s.pipe_in  = (tok_addr == ufpc_pkg::EP0_ADDR) ?
                      tok_is_in : tok_addr[7];            // [RULE1]
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s         <= '0;
      s.dp_oe_n <= 1'b1;
      s.dm_oe_n <= 1'b1;
    end
    else
      s <= next_s;
  end

  // outputs straight from the state register
  assign ifc.sfr_rdata      = s.rdata;
  assign ifc.usb_clk_active = s.clk_act;
  assign dp_out      = s.dp_out;
  assign dp_oe_n     = s.dp_oe_n;
  assign dm_out      = s.dm_out;
  assign dm_oe_n     = s.dm_oe_n;
  assign pullup_dp   = s.pullup_dp;
  assign pullup_dm   = s.pullup_dm;
  assign phy_suspend = s.phy_suspend;
  assign full_speed  = s.full_speed;
  assign pipe_hit    = s.pipe_hit;
  assign pipe_in     = s.pipe_in;
  assign pipe_ep     = s.pipe_ep;
endmodule : ufpc_device

// ### verilog/ufpc_host.sv
// firmware end: runs the indirect access procedures over the
// register path and direct transceiver control accesses
// assumes the device end answers reads one cycle after the strobe
`timescale 1ns/1ps
module ufpc_host (
  input  wire logic       clk,
  input  wire logic       rst_n,
  ufpc_sfr_if.host        ifc,
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_kind,
  input  wire logic [5:0] cmd_addr,
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_auto,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic      [7:0] rsp_data
);
  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_POLL = 3'h1,
    H_CHK  = 3'h3,
    H_ACT  = 3'h2,
    H_WDAT = 3'h6,
    H_RDAT = 3'h7,
    H_CAPT = 3'h5,
    H_FIN  = 3'h4
  } ufpc_hstate_t;

  typedef struct packed {
    ufpc_hstate_t st;    // sequencer state
    logic         phase; // fetch already launched
    logic [1:0]   kind;  // latched command kind
    logic         auto;  // latched auto-read choice
    logic [5:0]   addr;  // latched target
    logic [7:0]   data;  // latched write data
    logic [7:0]   sfr_addr;
    logic         sfr_rd;
    logic         sfr_wr;
    logic [7:0]   sfr_wdata;
    logic         cmd_ready;
    logic         rsp_valid;
    logic [7:0]   rsp_data;
  } ufpc_host_state_t;

  ufpc_host_state_t s;      // current state
  ufpc_host_state_t next_s; // next state

  // sequencer for the read and write procedures
  always_comb
  begin
    next_s           = s;
    next_s.sfr_rd    = 1'b0;
    next_s.sfr_wr    = 1'b0;
    next_s.rsp_valid = 1'b0;
    case (s.st)
      H_IDLE:
      begin
        if (cmd_valid && s.cmd_ready)
        begin
          next_s.kind  = cmd_kind;
          next_s.addr  = cmd_addr;
          next_s.data  = cmd_data;
          next_s.auto  = cmd_auto;
          next_s.phase = 1'b0;
          if (cmd_kind == ufpc_pkg::CMD_XCN_WRITE)
          begin
            next_s.sfr_addr  = ufpc_pkg::XCN_OFS;
            next_s.sfr_wdata = cmd_data;
            next_s.sfr_wr    = 1'b1;
            next_s.st        = H_FIN;
          end
          else if (cmd_kind == ufpc_pkg::CMD_XCN_READ)
          begin
            next_s.sfr_addr = ufpc_pkg::XCN_OFS;
            next_s.sfr_rd   = 1'b1;
            next_s.st       = H_RDAT;
          end
          else
          begin
            // first poll of busy
            next_s.sfr_addr = ufpc_pkg::ADR_OFS;          // [RULE11]
            next_s.sfr_rd   = 1'b1;                       // [RULE15]
            next_s.st       = H_POLL;
          end
        end
      end
      H_POLL:
        next_s.st = H_CHK;
      H_CHK:
      begin
        if (ifc.sfr_rdata[ufpc_pkg::ADR_BUSY])
        begin
          // still busy: poll again
          next_s.sfr_addr = ufpc_pkg::ADR_OFS;            // [RULE15]
          next_s.sfr_rd   = 1'b1;
          next_s.st       = H_POLL;
        end
        else if (s.phase)
        begin
          next_s.sfr_addr = ufpc_pkg::DAT_OFS;            // [RULE15]
          next_s.sfr_rd   = 1'b1;
          next_s.st       = H_RDAT;
        end
        else if (s.kind == ufpc_pkg::CMD_IND_READ)
        begin
          // address and busy in one write
          next_s.sfr_addr  = ufpc_pkg::ADR_OFS;
          next_s.sfr_wdata = {1'b1, s.auto, s.addr};      // [RULE15]
          next_s.sfr_wr    = 1'b1;
          next_s.phase     = 1'b1;
          next_s.st        = H_ACT;
        end
        else
        begin
          next_s.sfr_addr  = ufpc_pkg::ADR_OFS;
          next_s.sfr_wdata = {2'h0, s.addr};              // [RULE17]
          next_s.sfr_wr    = 1'b1;
          next_s.st        = H_WDAT;
        end
      end
      H_ACT:
      begin
        next_s.sfr_addr = ufpc_pkg::ADR_OFS;
        next_s.sfr_rd   = 1'b1;
        next_s.st       = H_POLL;
      end
      H_WDAT:
      begin
        next_s.sfr_addr  = ufpc_pkg::DAT_OFS;
        next_s.sfr_wdata = s.data;                        // [RULE17]
        next_s.sfr_wr    = 1'b1;
        next_s.st        = H_FIN;
      end
      H_RDAT:
        next_s.st = H_CAPT;
      H_CAPT:
      begin
        next_s.rsp_data  = ifc.sfr_rdata;
        next_s.rsp_valid = 1'b1;
        next_s.st        = H_IDLE;
      end
      H_FIN:
      begin
        next_s.rsp_valid = 1'b1;
        next_s.st        = H_IDLE;
      end
      default:
        next_s.st = H_IDLE;
    endcase
    // commands only while the usb clock runs
    next_s.cmd_ready = (next_s.st == H_IDLE) &
                       ifc.usb_clk_active;                // [RULE13]
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s    <= '0;
      s.st <= H_IDLE;
    end
    else
      s <= next_s;
  end

  assign ifc.sfr_addr  = s.sfr_addr;
  assign ifc.sfr_rd    = s.sfr_rd;
  assign ifc.sfr_wr    = s.sfr_wr;
  assign ifc.sfr_wdata = s.sfr_wdata;
  assign cmd_ready     = s.cmd_ready;
  assign rsp_valid     = s.rsp_valid;
  assign rsp_data      = s.rsp_data;
endmodule : ufpc_host

// ### test/ufpc_sfr_checker.sv
// checker on the register path between firmware end and device end
// assumes one shared clock and an active low asynchronous reset
`timescale 1ns/1ps
module ufpc_sfr_checker (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       usb_clk_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // decoded strobes per direct register
  wire logic rd_a = sfr_rd && sfr_addr == ufpc_pkg::ADR_OFS;
  wire logic wr_a = sfr_wr && sfr_addr == ufpc_pkg::ADR_OFS;
  wire logic rd_d = sfr_rd && sfr_addr == ufpc_pkg::DAT_OFS;
  wire logic wr_d = sfr_wr && sfr_addr == ufpc_pkg::DAT_OFS;
  wire logic rd_x = sfr_rd && sfr_addr == ufpc_pkg::XCN_OFS;
  wire logic wr_x = sfr_wr && sfr_addr == ufpc_pkg::XCN_OFS;
  logic       rd_a_q; // address register read last cycle
  logic       idle;   // last poll saw busy clear
  logic [6:0] adr_sh; // written auto bit and target
  logic [4:0] xcn_sh; // written control fields
  // shadows of what firmware wrote and saw
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_a_q <= 1'b0;
      idle   <= 1'b0;
      adr_sh <= 7'h00;
      xcn_sh <= 5'h00;
    end
    else
    begin
      rd_a_q <= rd_a;
      if (wr_a)
        adr_sh <= sfr_wdata[6:0];
      if (wr_x)
        xcn_sh <= sfr_wdata[7:3];
      // a launch or an auto relaunch makes data stale
      if ((wr_a && sfr_wdata[7]) || (rd_d && adr_sh[6]))
        idle <= 1'b0;
      else if (rd_a_q)
        idle <= !sfr_rdata[7];
    end
  end
  property p_one_dir;
    !(sfr_rd && sfr_wr);
  endproperty
  a_one_dir: assert property (p_one_dir)
    else $error("read and write strobes together");
  property p_xcn_back;
    rd_x |=> sfr_rdata[7:3] == xcn_sh;
  endproperty
  a_xcn_back: assert property (p_xcn_back)
    else $error("control fields read back wrong");
  property p_busy_set;
    wr_a && sfr_wdata[7] ##1 rd_a |=> sfr_rdata[7];
  endproperty
  a_busy_set: assert property (p_busy_set)
    else $error("busy not shown after launch");
  property p_busy_clr;
    wr_a && sfr_wdata[7] |-> ##[2:40] (rd_a_q && !sfr_rdata[7]);
  endproperty
  a_busy_clr: assert property (p_busy_clr)
    else $error("busy never cleared");
  property p_adr_keep;
    rd_a |=> sfr_rdata[6:0] == adr_sh;
  endproperty
  a_adr_keep: assert property (p_adr_keep)
    else $error("address field changed");
  property p_wr_idle;
    wr_a |-> idle;
  endproperty
  a_wr_idle: assert property (p_wr_idle)
    else $error("address written while busy");
  property p_dat_after_adr;
    wr_d |-> $past(wr_a);
  endproperty
  a_dat_after_adr: assert property (p_dat_after_adr)
    else $error("data write without address load");
  property p_rd_valid;
    rd_d |-> idle;
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("data read while busy");
  property p_clk_on;
    sfr_rd || sfr_wr |-> usb_clk_active;
  endproperty
  a_clk_on: assert property (p_clk_on)
    else $error("access with usb clock stopped");
endmodule : ufpc_sfr_checker

// ### test/usb_function_phy_control_tb.sv
// testbench joining firmware end and device end over the register path
// assumes 125 MHz clock and active low reset held ten cycles
`timescale 1ns/1ps
module usb_function_phy_control_tb;
  logic clk, rst_n, usb_on, vbus, dp_bus, dm_bus, tok_v, tok_in;
  logic dp_out, dp_oe_n, dm_out, dm_oe_n, pu_dp, pu_dm, susp, fs;
  logic hit, p_in, cmd_v, c_auto, ready, rsp_v;
  logic [1:0] p_ep, kind;
  logic [5:0] c_addr;
  logic [7:0] tok_a, c_data, rsp, ex;
  int bad_count, samples_checked, cycles;
  // token addresses and expected {hit, in, ep}
  logic [7:0] ta [10] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h81,
                          8'h82, 8'h83, 8'h04, 8'h80};
  logic [7:0] te [10] = '{8'h80, 8'hc0, 8'h81, 8'h82, 8'h83, 8'hc1,
                          8'hc2, 8'hc3, 8'h00, 8'h40};
  // wire level: forced drive wins over the bus side
  wire logic dp_lvl = dp_oe_n ? dp_bus : dp_out;
  wire logic dm_lvl = dm_oe_n ? dm_bus : dm_out;
  ufpc_sfr_if ifc ();
  ufpc_device u_ufpc_device (.clk(clk), .rst_n(rst_n), .ifc(ifc.dev),
    .usb_clk_on(usb_on), .vbus_in(vbus), .dp_in(dp_lvl), .dp_out(dp_out),
    .dp_oe_n(dp_oe_n), .dm_in(dm_lvl), .dm_out(dm_out), .dm_oe_n(dm_oe_n),
    .pullup_dp(pu_dp), .pullup_dm(pu_dm), .phy_suspend(susp),
    .full_speed(fs), .tok_valid(tok_v), .tok_addr(tok_a),
    .tok_is_in(tok_in), .pipe_hit(hit), .pipe_in(p_in), .pipe_ep(p_ep));
  ufpc_host u_ufpc_host (.clk(clk), .rst_n(rst_n), .ifc(ifc.host),
    .cmd_valid(cmd_v), .cmd_kind(kind), .cmd_addr(c_addr),
    .cmd_data(c_data), .cmd_auto(c_auto), .cmd_ready(ready),
    .rsp_valid(rsp_v), .rsp_data(rsp));
  ufpc_sfr_checker u_ufpc_sfr_checker (.clk(clk), .rst_n(rst_n),
    .sfr_addr(ifc.sfr_addr), .sfr_wr(ifc.sfr_wr), .sfr_rd(ifc.sfr_rd),
    .sfr_wdata(ifc.sfr_wdata), .sfr_rdata(ifc.sfr_rdata),
    .usb_clk_active(ifc.usb_clk_active));
  // free running clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one firmware command, waits for its response pulse
  task automatic cmd(input logic [1:0] k, input logic [5:0] a,
                     input logic [7:0] d, input logic au);
    while (ready !== 1'b1)
      @(negedge clk);
    {cmd_v, kind, c_addr, c_data, c_auto} = {1'b1, k, a, d, au};
    @(negedge clk);
    cmd_v = 1'b0;
    while (rsp_v !== 1'b1)
      @(negedge clk);
    repeat (4) @(negedge clk);
  endtask : cmd
  task automatic finish_test();
    $display("checked=%0d errors=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      finish_test();
    end
  end
  // main sequence
  initial
  begin
    {rst_n, usb_on, vbus, dp_bus, dm_bus, tok_v, tok_in, tok_a} = '0;
    {cmd_v, kind, c_addr, c_data, c_auto} = '0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk({7'h0, ready}, 8'h00);
    usb_on = 1'b1;
    vbus = 1'b1;
    cmd(2'h3, 6'h0, 8'h0, 1'b0);
    chk(rsp, 8'h00);
    // pull-up placement, speed and suspend
    cmd(2'h2, 6'h0, 8'he0, 1'b0);
    chk({4'h0, pu_dp, pu_dm, susp, fs}, 8'h09);
    cmd(2'h2, 6'h0, 8'h80, 1'b0);
    chk({4'h0, pu_dp, pu_dm, susp, fs}, 8'h06);
    vbus = 1'b0;
    repeat (4) @(negedge clk);
    chk({4'h0, pu_dp, pu_dm, susp, fs}, 8'h02);
    vbus = 1'b1;
    cmd(2'h2, 6'h0, 8'h20, 1'b0);
    chk({4'h0, pu_dp, pu_dm, susp, fs}, 8'h03);
    // every test code, status bits written as ones
    dp_bus = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      cmd(2'h2, 6'h0, {3'b010, c[1:0], 3'b111}, 1'b0);
      chk({6'h0, dp_oe_n, dm_oe_n}, (c == 0) ? 8'h03 : 8'h00);
      ex = {3'b010, c[1:0], 3'b000};
      ex[1] = (c == 0) || (c == 1);
      ex[0] = (c == 2);
      ex[2] = ex[1] && !ex[0];
      cmd(2'h3, 6'h0, 8'h0, 1'b0);
      chk(rsp, ex);
    end
    cmd(2'h2, 6'h0, 8'h00, 1'b0);
    {dp_bus, dm_bus} = 2'b01;
    repeat (3) @(negedge clk);
    cmd(2'h3, 6'h0, 8'h0, 1'b0);
    chk(rsp, 8'h01);
    // endpoint address map
    for (int i = 0; i < 10; i++)
    begin
      tok_a = ta[i];
      tok_in = i[0];
      tok_v = 1'b1;
      @(negedge clk);
      tok_v = 1'b0;
      chk({hit, p_in, 4'h0, p_ep}, te[i]);
    end
    // indirect access and endpoint indexing
    cmd(2'h1, 6'h00, 8'h5a, 1'b0);
    cmd(2'h0, 6'h00, 8'h0, 1'b0);
    chk(rsp, 8'h5a);
    cmd(2'h1, ufpc_pkg::INDEX_ADDR, 8'h01, 1'b0);
    cmd(2'h1, ufpc_pkg::IDX_BASE, 8'h11, 1'b0);
    cmd(2'h1, ufpc_pkg::IDX_BASE, 8'h12, 1'b0);
    cmd(2'h1, ufpc_pkg::INDEX_ADDR, 8'h02, 1'b0);
    cmd(2'h1, ufpc_pkg::IDX_BASE, 8'h22, 1'b0);
    cmd(2'h1, ufpc_pkg::INDEX_ADDR, 8'h01, 1'b0);
    cmd(2'h0, ufpc_pkg::IDX_BASE, 8'h0, 1'b1);
    chk(rsp, 8'h12);
    cmd(2'h1, ufpc_pkg::INDEX_ADDR, 8'h02, 1'b0);
    cmd(2'h0, ufpc_pkg::IDX_BASE, 8'h0, 1'b0);
    chk(rsp, 8'h22);
    cmd(2'h1, 6'h20, 8'h33, 1'b0);
    cmd(2'h0, 6'h20, 8'h0, 1'b0);
    chk(rsp, 8'h00);
    finish_test();
  end
endmodule : usb_function_phy_control_tb
